// File: sadc_top.v
// Converter control top: APB registers, pin configuration, conversion control and interrupt
// Overview of operation
// - Three clock select bits pick system clock divide 2..64 or internal RC clock.
// - Channel select value routes that analog input to the sample-and-hold.
// - Writing one to go while powered starts; reads one until conversion ends.
// - Power bit one powers converter; zero shuts it off.
// - Unimplemented control bits read as zero.
// - Justify bit selects right or left aligned result with zero fill.
// - Pin config field sets analog pins and reference sources per code table.
// - Reset forces all analog-capable pins to analog mode.
// - Reset clears control, status and mask registers, powers converter off, aborts conversion.
// - Completion loads result, clears go, sets complete flag.
// - Conversion runs during sleep only with internal RC clock.
// - Ten-bit result by successive approximation of held sample.
// - Each conversion takes twelve conversion clock periods.
// - Result bytes are not cleared by reset.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire sleep_mode,
  input wire rc_tick,
  input wire comparator,
  output reg converter_power_on,
  output reg [2:0] input_channel_select,
  output reg sample_hold_track,
  output reg [9:0] dac_code,
  output reg [7:0] pin_analog,
  output reg vref_pos_ext,
  output reg vref_neg_ext
);
  reg [7:0] ctrl0_reg;
  reg [7:0] ctrl1_reg;
  reg [9:0] result_reg;
  reg flag_reg;
  reg mask_reg;
  reg [7:0] rdata_next;
  reg rd_err_next;
  reg [9:0] pcfg_word;
  wire wr_en;
  wire setup;
  wire [7:0] wb;
  wire go_write;
  wire go_clear;
  wire start;
  wire abort;
  wire tick;
  wire busy;
  wire done;
  wire [9:0] code;
  wire [2:0] conv_clock_select;
  wire [3:0] pin_config_select;
  wire result_justify_select;
  wire [7:0] result_high_byte;
  wire [7:0] result_low_byte;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign wb = pwdata[7:0];
  assign conv_clock_select = {ctrl1_reg[`SADC_C1_CLKTOP], ctrl0_reg[`SADC_C0_CLK_HI:`SADC_C0_CLK_LO]};
  assign pin_config_select = ctrl1_reg[`SADC_C1_PCFG_HI:`SADC_C1_PCFG_LO];
  assign result_justify_select = ctrl1_reg[`SADC_C1_JUST];
  assign go_write = wr_en && paddr == `SADC_OFS_CTRL0;
  assign start = go_write && wb[`SADC_C0_GO] && wb[`SADC_C0_ON] && !busy;
  assign go_clear = go_write && (!wb[`SADC_C0_GO] || !wb[`SADC_C0_ON]);
  assign abort = busy && go_clear;

  // Pin map {analog[7:0], vref+ external, vref- external}
  function [9:0] pin_map;
    input [3:0] p;
    begin
      case (p)
        4'h0: pin_map = {8'hFF, 2'b00};
        4'h1: pin_map = {8'hFF, 2'b10};
        4'h2: pin_map = {8'h1F, 2'b00};
        4'h3: pin_map = {8'h1F, 2'b10};
        4'h4: pin_map = {8'h0B, 2'b00};
        4'h5: pin_map = {8'h0B, 2'b10};
        4'h6: pin_map = {8'h00, 2'b00};
        4'h7: pin_map = {8'h00, 2'b00};
        4'h8: pin_map = {8'hFF, 2'b11};
        4'h9: pin_map = {8'h3F, 2'b00};
        4'hA: pin_map = {8'h3F, 2'b10};
        4'hB: pin_map = {8'h3F, 2'b11};
        4'hC: pin_map = {8'h1F, 2'b11};
        4'hD: pin_map = {8'h0F, 2'b11};
        4'hE: pin_map = {8'h01, 2'b00};
        default: pin_map = {8'h0D, 2'b11};
      endcase
    end
  endfunction

  always @* begin
    pcfg_word = pin_map(pin_config_select);
  end

  sadc_clkdiv u_div (
    .clk(pclk),
    .rst_n(presetn),
    .run(busy),
    .sleep_mode(sleep_mode),
    .rc_tick(rc_tick),
    .sel(conv_clock_select),
    .tick(tick)
  );

  sadc_sar #(
    .N(`SADC_RES_BITS)
  ) u_sar (
    .clk(pclk),
    .rst_n(presetn),
    .start(start),
    .abort(abort),
    .tick(tick),
    .cmp(comparator),
    .busy(busy),
    .done(done),
    .code(code)
  );

  // Justified views of the result
  assign result_high_byte = result_justify_select ? {6'h00, result_reg[9:8]} : result_reg[9:2];
  assign result_low_byte = result_justify_select ? result_reg[7:0] : {result_reg[1:0], 6'h00};

  // Control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `SADC_CTRL0_RST;
      ctrl1_reg <= `SADC_CTRL1_RST;
      mask_reg <= `SADC_MASK_RST;
    end else begin
      if (go_write) begin
        ctrl0_reg <= wb & `SADC_C0_WMASK;
        ctrl0_reg[`SADC_C0_GO] <= start || (busy && wb[`SADC_C0_GO] && wb[`SADC_C0_ON]);
      end else if (done) begin
        ctrl0_reg[`SADC_C0_GO] <= 1'b0;
      end
      if (wr_en && paddr == `SADC_OFS_CTRL1) begin
        ctrl1_reg <= wb & `SADC_C1_WMASK;
      end
      if (wr_en && paddr == `SADC_OFS_MASK) begin
        mask_reg <= wb[`SADC_STAT_DONE];
      end
    end
  end

  // Completion flag, set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= `SADC_STAT_RST;
    end else if (done) begin
      flag_reg <= 1'b1;
    end else if (wr_en && paddr == `SADC_OFS_STAT && wb[`SADC_STAT_DONE]) begin
      flag_reg <= 1'b0;
    end
  end

  // Result holds across reset
  always @(posedge pclk) begin
    if (done) begin
      result_reg <= code;
    end
  end

  // Read decode
  always @* begin
    rdata_next = 8'h00;
    rd_err_next = 1'b0;
    if (paddr == `SADC_OFS_CTRL0) begin
      rdata_next = ctrl0_reg;
    end else if (paddr == `SADC_OFS_CTRL1) begin
      rdata_next = ctrl1_reg;
    end else if (paddr == `SADC_OFS_RESH) begin
      rdata_next = result_high_byte;
    end else if (paddr == `SADC_OFS_RESL) begin
      rdata_next = result_low_byte;
    end else if (paddr == `SADC_OFS_STAT) begin
      rdata_next = {7'h00, flag_reg};
    end else if (paddr == `SADC_OFS_MASK) begin
      rdata_next = {7'h00, mask_reg};
    end else begin
      rd_err_next = 1'b1;
    end
  end

  // APB answer, one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && rd_err_next;
      if (setup && !pwrite) begin
        prdata <= {24'h000000, rdata_next};
      end
    end
  end

  // Analog-side outputs and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      converter_power_on <= 1'b0;
      input_channel_select <= 3'h0;
      sample_hold_track <= 1'b0;
      dac_code <= 10'h000;
      pin_analog <= `SADC_PINS_RST;
      vref_pos_ext <= 1'b0;
      vref_neg_ext <= 1'b0;
    end else begin
      irq <= flag_reg && mask_reg;
      converter_power_on <= ctrl0_reg[`SADC_C0_ON];
      input_channel_select <= ctrl0_reg[`SADC_C0_CH_HI:`SADC_C0_CH_LO];
      sample_hold_track <= ctrl0_reg[`SADC_C0_ON] && !busy;
      dac_code <= busy ? code : 10'h000;
      pin_analog <= pcfg_word[9:2];
      vref_pos_ext <= pcfg_word[1];
      vref_neg_ext <= pcfg_word[0];
    end
  end
endmodule

// File: sadc_regs.vh
// Register map, field positions, reset values and timing counts of the converter control
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
`define SADC_OFS_CTRL0 8'h00
`define SADC_OFS_CTRL1 8'h04
`define SADC_OFS_RESH 8'h08
`define SADC_OFS_RESL 8'h0C
`define SADC_OFS_STAT 8'h10
`define SADC_OFS_MASK 8'h14
`define SADC_C0_CLK_HI 7
`define SADC_C0_CLK_LO 6
`define SADC_C0_CH_HI 5
`define SADC_C0_CH_LO 3
`define SADC_C0_GO 2
`define SADC_C0_ON 0
`define SADC_C0_WMASK 8'hFD
`define SADC_C1_JUST 7
`define SADC_C1_CLKTOP 6
`define SADC_C1_PCFG_HI 3
`define SADC_C1_PCFG_LO 0
`define SADC_C1_WMASK 8'hCF
`define SADC_STAT_DONE 0
`define SADC_CTRL0_RST 8'h00
`define SADC_CTRL1_RST 8'h00
`define SADC_STAT_RST 1'b0
`define SADC_MASK_RST 1'b0
`define SADC_PINS_RST 8'hFF
`define SADC_CONV_PERIODS 4'd12
`define SADC_RES_BITS 10
`endif

// File: sadc_clkdiv.v
// Conversion clock enable generator: system clock divider or internal RC tick
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_clkdiv (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire sleep_mode,
  input wire rc_tick,
  input wire [2:0] sel,
  output reg tick
);
  reg [5:0] cnt_reg;
  wire use_rc;
  wire [5:0] last;

  function [5:0] div_last;
    input [2:0] s;
    begin
      case (s)
        3'h0: div_last = 6'h01;
        3'h1: div_last = 6'h07;
        3'h2: div_last = 6'h1F;
        3'h4: div_last = 6'h03;
        3'h5: div_last = 6'h0F;
        3'h6: div_last = 6'h3F;
        default: div_last = 6'h01;
      endcase
    end
  endfunction

  assign use_rc = (sel[1:0] == 2'b11);
  assign last = div_last(sel);

  always @* begin
    if (!run) begin
      tick = 1'b0;
    end else if (use_rc) begin
      tick = rc_tick;
    end else begin
      tick = !sleep_mode && (cnt_reg == last);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 6'h00;
    end else if (!run || use_rc || sleep_mode || cnt_reg == last) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule

// File: sadc_sar.v
// Successive approximation sequencer, twelve conversion periods per result
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_sar #(
  parameter N = `SADC_RES_BITS
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  input wire tick,
  input wire cmp,
  output reg busy,
  output reg done,
  output reg [N-1:0] code
);
  reg [3:0] cnt_reg;
  reg [N-1:0] bit_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_reg <= 4'h0;
      bit_reg <= {N{1'b0}};
      code <= {N{1'b0}};
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        cnt_reg <= 4'h0;
      end else if (start && !busy) begin
        busy <= 1'b1;
        cnt_reg <= 4'h0;
        bit_reg <= {1'b1, {(N-1){1'b0}}};
        code <= {1'b1, {(N-1){1'b0}}};
      end else if (busy && tick) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= 4'h1 && cnt_reg <= 4'd10) begin
          code <= (cmp ? code : (code & ~bit_reg)) | (bit_reg >> 1);
          bit_reg <= bit_reg >> 1;
        end
        if (cnt_reg == `SADC_CONV_PERIODS - 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: sadc_assertions.sv
// Port-level checker of the converter control, bound to its top
`timescale 1ns/1ns
module sadc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic converter_power_on,
  input wire logic sample_hold_track,
  input wire logic [9:0] dac_code,
  input wire logic [7:0] pin_analog
);
  wire wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY_ONE: assert property (psel && !penable |=> pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_SLVERR: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped");
  AST_OKAY: assert property (pready && paddr < 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  AST_RD_HI: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
    else $error("read data not zero");
  AST_PWR_ON: assert property (wr0 && pwdata[0] |-> ##[1:2] converter_power_on)
    else $error("power not on");
  AST_PWR_OFF: assert property (wr0 && !pwdata[0] |-> ##[1:2] !converter_power_on)
    else $error("power not off");
  AST_DAC_IDLE: assert property (sample_hold_track |-> dac_code == 10'h000)
    else $error("trial code while tracking");
  AST_PIN_RESET: assert property ($rose(presetn) |-> pin_analog == 8'hFF)
    else $error("pins not analog after reset");
  AST_CONV_LEN: assert property ($fell(sample_hold_track) && converter_power_on |-> !sample_hold_track [*8])
    else $error("conversion too short");
  cover property (wr0 && pwdata[2]);
  cover property ($rose(sample_hold_track));
  cover property (pready && pslverr);
endmodule
bind sadc_top sadc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .converter_power_on, .sample_hold_track, .dac_code, .pin_analog);

// File: sadc_analog_model.sv
// Sample-and-hold, comparator and RC oscillator model
`timescale 1ns/1ns
module sadc_analog_model (
  input wire logic pclk,
  input wire logic sample_hold_track,
  input wire logic [2:0] input_channel_select,
  input wire logic [9:0] dac_code,
  output logic comparator,
  output logic rc_tick
);
  logic [9:0] vin [8];
  logic [9:0] held;
  logic [2:0] rc_cnt = 3'h0;
  initial rc_tick = 1'b0;
  always @(posedge pclk) begin
    if (sample_hold_track) held <= vin[input_channel_select];
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
  end
  assign comparator = held >= dac_code;
endmodule

// File: sar_adc_control_test.sv
// Self-checking bench of the converter control
`timescale 1ns/1ns
module sar_adc_control_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'd53799;
  logic pready, pslverr, irq, rc_tick, comparator, converter_power_on, sample_hold_track;
  logic vref_pos_ext, vref_neg_ext, j;
  logic [2:0] input_channel_select, sel;
  logic [9:0] dac_code, v;
  logic [7:0] pin_analog, c0;
  logic [7:0] pmap [16] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h0B, 8'h0B, 8'h00, 8'h00,
    8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h0D};
  logic [15:0] vpm = 16'hBD2A, vnm = 16'hB900;
  logic [32:0] exp_q [$];
  int failures = 0, comparisons = 0, n, i, d;
  initial forever #20 pclk = ~pclk;
  sadc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .sleep_mode, .rc_tick, .comparator, .converter_power_on, .input_channel_select,
    .sample_hold_track, .dac_code, .pin_analog, .vref_pos_ext, .vref_neg_ext);
  sadc_analog_model u_ana (.pclk, .sample_hold_track, .input_channel_select, .dac_code, .comparator, .rc_tick);
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(string s, logic [32:0] e, logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] dt);
    int k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 50);
    if (k >= 50) begin
      failures++;
      conclude();
    end else begin
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic er = 0);
    exp_q.push_back({er, 24'h0, e});
    bus(0, a, 0);
  endtask
  task automatic wt(logic lv, output int c);
    c = 0;
    while (sample_hold_track !== lv && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 3000) failures++;
    if (c >= 3000) conclude();
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("read", exp_q.pop_front(), {pslverr, prdata});
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("pins", 8'hFF, pin_analog);
    for (i = 0; i < 6; i++) if (i < 2 || i > 3) rd(8'(i * 4), 8'h00);
    rd(8'h18, 8'h00, 1);
    bus(1, 8'h00, 32'hF3);
    rd(8'h00, 8'hF1);
    bus(1, 8'h04, 32'hFF);
    rd(8'h04, 8'hCF);
    for (i = 0; i < 16; i++) begin
      bus(1, 8'h04, i);
      repeat (2) @(posedge pclk);
      chk("pins", pmap[i], pin_analog);
      chk("vref", {vpm[i], vnm[i]}, {vref_pos_ext, vref_neg_ext});
    end
    for (i = 0; i < 8; i++) begin
      sel = 3'(i);
      d = (sel[1:0] == 2'b11) ? 5 : (sel[2] ? 4 : 2) << (2 * sel[1:0]);
      v = 10'(xs());
      j = v[5];
      c0 = {sel[1:0], 3'(xs()), 3'b001};
      u_ana.vin[c0[5:3]] = v;
      sleep_mode <= (sel[1:0] == 2'b11);
      bus(1, 8'h04, {j, sel[2], 6'h0});
      bus(1, 8'h14, i & 1);
      bus(1, 8'h00, c0);
      bus(1, 8'h00, c0 | 8'h04);
      rd(8'h00, c0 | 8'h04);
      wt(0, n);
      wt(1, n);
      chk("length", 1, n > 11 * d - 5 && n < 12 * d + 5);
      repeat (2) @(posedge pclk);
      chk("irq", i & 1, irq);
      rd(8'h10, 8'h01);
      rd(8'h00, c0);
      rd(8'h08, j ? {6'h0, v[9:8]} : v[9:2]);
      rd(8'h0C, j ? v[7:0] : {v[1:0], 6'h0});
      bus(1, 8'h10, 1);
      rd(8'h10, 8'h00);
      chk("irq", 0, irq);
      repeat (2 * d) @(posedge pclk);
    end
    bus(1, 8'h00, 32'h00);
    @(posedge pclk);
    chk("power", 0, converter_power_on);
    bus(1, 8'h00, 32'h05);
    repeat (60) @(posedge pclk);
    rd(8'h00, 8'h05);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("pins", 8'hFF, pin_analog);
    rd(8'h00, 8'h00);
    rd(8'h10, 8'h00);
    conclude();
  end
endmodule
